// [verilog/xfer_exec.sv]
// Executes data transfer, program memory, I/O, stack, rotate and flag operations.
// Assumes memories answer in the strobe cycle; external data acks on a pin.
`timescale 1ns/1ns
// Contract
// - Pre-decrement load lowers pointer, then loads; two cycles, flags kept.
// - Offset load reads pointer plus offset in two cycles, pointer kept.
// - Post-increment load reads at pointer, then adds one; one cycle.
// - Direct store writes source to instruction address in two cycles.
// - Post-increment store writes at pointer, then adds one; one cycle.
// - Pre-decrement store lowers pointer, then writes; two cycles.
// - Offset store writes at pointer plus offset in two cycles.
// - Program byte read loads Z byte into r0 or named register; three cycles.
// - Extended program read puts the page register above Z; three cycles.
// - Program word write stores r1:r0 at page:Z; post form adds two.
// - I/O in and out move one byte in one cycle, no flags.
// - Push takes one cycle, pop takes two.
// - Rotate left through carry updates Z, C, N, V, H in one cycle.
// - Rotate right through carry updates Z, C, N and V.
// - I/O bit set and clear force one bit in one cycle.
// - Bit to flag copies a register bit into T only.
// - Flag to bit copies T into a register bit, no flags.
// - Overflow set and clear force V in one cycle.
// - Half carry set and clear force H in one cycle.
// - Sign set and clear force S in one cycle.
// - Data accesses to internal SRAM take one extra cycle.
// - External memory accesses may take a different cycle count.
module xfer_exec #(
  parameter logic [15:0] SRAM_BASE = 16'h1000,
  parameter logic [15:0] SRAM_LAST = 16'h4fff,
  parameter logic [15:0] EXT_BASE  = 16'h8000,
  parameter logic [15:0] SP_RESET  = 16'h4fff
) (
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  input  wire logic            op_valid,
  input  xfer_pkg::op_t        op_code,
  input  xfer_pkg::mode_t      op_mode,
  input  xfer_pkg::ptr_t       op_ptr,
  input  wire logic [4:0]      op_reg,
  input  wire logic [2:0]      op_bit,
  input  wire logic [5:0]      op_offset,
  input  wire logic [15:0]     op_addr,
  input  wire logic [5:0]      op_io_addr,
  input  wire logic [7:0]      extended_z_page,
  input  wire logic [7:0]      data_rdata,
  input  wire logic [7:0]      prog_rdata,
  input  wire logic [7:0]      io_rdata,
  input  wire logic            ext_ack,
  input  wire logic            reg_load,
  input  wire logic [4:0]      reg_load_idx,
  input  wire logic [7:0]      reg_load_data,
  input  wire logic [4:0]      reg_sel,
  output logic                 op_ready,
  output logic                 op_done,
  output logic [15:0]          data_addr,
  output logic [7:0]           data_wdata,
  output logic                 data_rd,
  output logic                 data_wr,
  output logic [23:0]          prog_addr,
  output logic [15:0]          prog_wdata,
  output logic                 prog_rd,
  output logic                 prog_wr,
  output logic [5:0]           io_addr,
  output logic [7:0]           io_wdata,
  output logic [7:0]           io_mask,
  output logic                 io_rd,
  output logic                 io_wr,
  output logic [7:0]           status_flags_register,
  output logic [15:0]          stack_pointer,
  output logic [7:0]           reg_value
);

  logic [7:0]        regs [0:31];
  xfer_pkg::state_t  state;
  xfer_pkg::cap_t    cap_kind;
  logic [2:0]        cnt;
  logic [4:0]        dest;
  logic              ext_pend;
  logic [5:0]        strb;
  logic              ack_s1;
  logic              ack_s2;
  logic              ack_s3;
  logic [7:0]        next_flags;

  // Low register index of a pointer pair.
  function automatic logic [4:0] ptr_lo(xfer_pkg::ptr_t p);
    ptr_lo = (p == xfer_pkg::PTR_X) ? xfer_pkg::X_LO :
             (p == xfer_pkg::PTR_Y) ? xfer_pkg::Y_LO : xfer_pkg::Z_LO;
  endfunction

  // Current 16-bit value of a pointer pair.
  function automatic logic [15:0] ptr_of(xfer_pkg::ptr_t p);
    ptr_of = {regs[ptr_lo(p) + 5'h01], regs[ptr_lo(p)]};
  endfunction

  // Operation decode.
  wire acc      = op_valid & op_ready;
  wire is_ld    = (op_code == xfer_pkg::OP_LOAD);
  wire is_st    = (op_code == xfer_pkg::OP_STORE);
  wire is_prd   = (op_code == xfer_pkg::OP_PROG_READ) ||
                  (op_code == xfer_pkg::OP_PROG_READ_EXT);
  wire is_pwr   = (op_code == xfer_pkg::OP_PROG_WRITE);
  wire is_push  = (op_code == xfer_pkg::OP_PUSH);
  wire is_pop   = (op_code == xfer_pkg::OP_POP);
  wire m_post   = (op_mode == xfer_pkg::AM_POST_INC);
  wire m_pre    = (op_mode == xfer_pkg::AM_PRE_DEC);
  wire m_off    = (op_mode == xfer_pkg::AM_OFFSET);
  wire ack_seen = ack_s2 & ack_s3;

  // Program operations always walk Z; data operations use the chosen pair.
  wire xfer_pkg::ptr_t use_ptr = (is_prd || is_pwr) ? xfer_pkg::PTR_Z : op_ptr;
  wire [4:0]  use_lo   = ptr_lo(use_ptr);
  wire [15:0] ptr_val  = {regs[use_lo + 5'h01], regs[use_lo]};
  wire [15:0] z_val    = {regs[xfer_pkg::Z_LO + 5'h01], regs[xfer_pkg::Z_LO]};
  wire [15:0] step     = is_pwr ? xfer_pkg::WORD_STEP : xfer_pkg::PTR_STEP;
  wire [15:0] next_ptr = m_pre ? ptr_val - xfer_pkg::PTR_STEP : ptr_val + step;
  wire        ptr_moves = ((is_ld || is_st) && (m_post || m_pre)) ||
                          ((is_prd || is_pwr) && m_post);

  // Data address: pre-decrement uses the lowered pointer, offset adds q.
  wire [15:0] ind_ea  = m_pre ? ptr_val - xfer_pkg::PTR_STEP :
                        m_off ? ptr_val + {10'h000, op_offset} : ptr_val;
  wire [15:0] data_ea = (op_code == xfer_pkg::OP_LOAD_DIRECT ||
                         op_code == xfer_pkg::OP_STORE_DIRECT) ? op_addr :
                        is_push ? stack_pointer :
                        is_pop  ? stack_pointer + xfer_pkg::PTR_STEP : ind_ea;
  wire        uses_data = xfer_pkg::is_data(op_code);
  wire        in_sram   = (data_ea >= SRAM_BASE) && (data_ea <= SRAM_LAST);
  wire        to_ext    = uses_data && (data_ea >= EXT_BASE);
  wire [2:0]  total     = xfer_pkg::base_cycles(op_code, op_mode) +
                          ((uses_data && in_sram) ? xfer_pkg::SRAM_EXTRA : 3'h0);

  // Program address: page register for every program operation except the plain program read.
  wire [7:0]  page    = (op_code == xfer_pkg::OP_PROG_READ) ? xfer_pkg::NO_PAGE
                                                           : extended_z_page;
  wire [23:0] prog_ea = {page, z_val};

  wire [7:0] src      = regs[op_reg];
  wire [7:0] bit_mask = 8'h01 << op_bit;
  wire [4:0] ld_dest  = (op_mode == xfer_pkg::AM_IMPLIED) ? 5'h00 : op_reg;
  wire [7:0] t_put    = status_flags_register[xfer_pkg::FLAG_T] ? (src | bit_mask)
                                                                : (src & ~bit_mask);
  wire [7:0] cap_val  = (cap_kind == xfer_pkg::CAP_PROG) ? prog_rdata :
                        (cap_kind == xfer_pkg::CAP_IO)   ? io_rdata : data_rdata;
  wire       cap_now  = (cap_kind != xfer_pkg::CAP_NONE) &&
                        (((state == xfer_pkg::ST_RUN) && !ext_pend && (strb != 6'h00)) ||
                         ((state == xfer_pkg::ST_EXT) && ack_seen));
  wire xfer_pkg::cap_t next_cap =
      (is_ld || is_pop || op_code == xfer_pkg::OP_LOAD_DIRECT) ? xfer_pkg::CAP_DATA :
      is_prd ? xfer_pkg::CAP_PROG :
      (op_code == xfer_pkg::OP_IO_IN) ? xfer_pkg::CAP_IO : xfer_pkg::CAP_NONE;

  wire [7:0] rot_val;
  wire       rot_c;
  wire       rot_z;
  wire       rot_n;
  wire       rot_v;
  wire       rot_h;

  rotate_carry_unit u_rot (
    .value    (src),
    .carry_in (status_flags_register[xfer_pkg::FLAG_C]),
    .to_left  (op_code == xfer_pkg::OP_ROL),
    .result   (rot_val),
    .flag_c   (rot_c),
    .flag_z   (rot_z),
    .flag_n   (rot_n),
    .flag_v   (rot_v),
    .flag_h   (rot_h)
  );

  // Strobe vector order: data read, data write, prog read, prog write, io read, io write.
  assign {data_rd, data_wr, prog_rd, prog_wr, io_rd, io_wr} = strb;

  // Flag results; every other operation leaves the flags as they are.
  always_comb
  begin
    next_flags = status_flags_register;
    case (op_code)
      xfer_pkg::OP_ROL, xfer_pkg::OP_ROR:
      begin
        next_flags[xfer_pkg::FLAG_C] = rot_c;
        next_flags[xfer_pkg::FLAG_Z] = rot_z;
        next_flags[xfer_pkg::FLAG_N] = rot_n;
        next_flags[xfer_pkg::FLAG_V] = rot_v;
        if (op_code == xfer_pkg::OP_ROL)
          next_flags[xfer_pkg::FLAG_H] = rot_h;
      end
      xfer_pkg::OP_BIT_TO_FLAG: next_flags[xfer_pkg::FLAG_T] = src[op_bit];
      xfer_pkg::OP_FLAG_SET:    next_flags[op_bit] = 1'b1;
      xfer_pkg::OP_FLAG_CLR:    next_flags[op_bit] = 1'b0;
      default:                  next_flags = status_flags_register;
    endcase
  end

  // Three-stage catch of the external bus acknowledge pin.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      {ack_s1, ack_s2, ack_s3} <= 3'h0;
    else
      {ack_s1, ack_s2, ack_s3} <= {ext_ack, ack_s1, ack_s2};
  end

  // Sequencer: internal accesses strobe one cycle, then count out the cycle total with any SRAM extra; external ones hold strobes until the ack.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state    <= xfer_pkg::ST_IDLE;
      op_ready <= 1'b1;
      op_done  <= 1'b0;
      strb     <= 6'h00;
      cnt      <= 3'h0;
      ext_pend <= 1'b0;
      dest     <= 5'h00;
      cap_kind <= xfer_pkg::CAP_NONE;
    end
    else
    begin
      op_done <= 1'b0;
      case (state)
        xfer_pkg::ST_IDLE:
          if (acc)
          begin
            op_ready <= 1'b0;
            state    <= xfer_pkg::ST_RUN;
            cnt      <= total;
            ext_pend <= to_ext;
            dest     <= is_prd ? ld_dest : op_reg;
            cap_kind <= next_cap;
            strb <= {next_cap == xfer_pkg::CAP_DATA,
                     is_st || is_push || op_code == xfer_pkg::OP_STORE_DIRECT,
                     is_prd, is_pwr, op_code == xfer_pkg::OP_IO_IN,
                     op_code == xfer_pkg::OP_IO_OUT || op_code == xfer_pkg::OP_IO_SET ||
                     op_code == xfer_pkg::OP_IO_CLR};
          end
        xfer_pkg::ST_RUN:
          if (ext_pend)
            state <= ack_seen ? xfer_pkg::ST_RUN : xfer_pkg::ST_EXT;
          else
          begin
            strb <= 6'h00;
            cnt  <= cnt - 3'h1;
            if (cnt == xfer_pkg::CYC_ONE)
            begin
              state    <= xfer_pkg::ST_IDLE;
              op_ready <= 1'b1;
              op_done  <= 1'b1;
            end
          end
        xfer_pkg::ST_EXT:
          if (ack_seen)
          begin
            strb     <= 6'h00;
            state    <= xfer_pkg::ST_IDLE;
            op_ready <= 1'b1;
            op_done  <= 1'b1;
          end
        default: state <= xfer_pkg::ST_IDLE;
      endcase
    end
  end

  // Addresses and write data, latched with the request.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      data_addr  <= 16'h0000;
      data_wdata <= 8'h00;
      prog_addr  <= 24'h000000;
      prog_wdata <= 16'h0000;
      io_addr    <= 6'h00;
      io_wdata   <= 8'h00;
      io_mask    <= 8'h00;
    end
    else if (acc)
    begin
      data_addr  <= data_ea;
      data_wdata <= src;
      prog_addr  <= prog_ea;
      prog_wdata <= {regs[1], regs[0]};
      io_addr    <= op_io_addr;
      io_wdata   <= (op_code == xfer_pkg::OP_IO_OUT) ? src :
                    (op_code == xfer_pkg::OP_IO_SET) ? xfer_pkg::ALL_ONES : 8'h00;
      io_mask    <= (op_code == xfer_pkg::OP_IO_OUT) ? xfer_pkg::ALL_ONES : bit_mask;
    end
  end

  // Register file: captured load data, pointer steps, in-place results.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 32; i++)
        regs[i] <= 8'h00;
    end
    else if (cap_now)
      regs[dest] <= cap_val;
    else if (acc)
    begin
      if (ptr_moves)
      begin
        regs[use_lo]         <= next_ptr[7:0];
        regs[use_lo + 5'h01] <= next_ptr[15:8];
      end
      if (op_code == xfer_pkg::OP_ROL || op_code == xfer_pkg::OP_ROR)
        regs[op_reg] <= rot_val;
      else if (op_code == xfer_pkg::OP_FLAG_TO_BIT)
        regs[op_reg] <= t_put;
    end
    else if (reg_load && state == xfer_pkg::ST_IDLE)
      regs[reg_load_idx] <= reg_load_data;
  end

  // Status flags, stack pointer and register peek port.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      status_flags_register <= 8'h00;
      stack_pointer         <= SP_RESET;
      reg_value             <= 8'h00;
    end
    else
    begin
      reg_value <= regs[reg_sel];
      if (acc)
      begin
        status_flags_register <= next_flags;
        if (is_push)
          stack_pointer <= stack_pointer - xfer_pkg::PTR_STEP;
        else if (is_pop)
          stack_pointer <= stack_pointer + xfer_pkg::PTR_STEP;
      end
    end
  end

  // Busy-length counter for the checks below.
  logic [3:0] busy_len;
  logic [2:0] exp_total;
  logic       exp_ext;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy_len  <= 4'h0;
      exp_total <= 3'h0;
      exp_ext   <= 1'b0;
    end
    else if (acc)
    begin
      busy_len  <= 4'h0;
      exp_total <= total;
      exp_ext   <= to_ext;
    end
    else if (!op_ready)
      busy_len <= busy_len + 4'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_predec_addr: assert property (acc && (is_ld || is_st) && m_pre |=>
    data_addr == $past(ptr_val) - 16'h0001 && (data_rd || data_wr))
    else $error("pre-decrement address wrong");
  a_offset_addr: assert property (acc && (is_ld || is_st) && m_off |=>
    data_addr == $past(ptr_val) + {10'h000, $past(op_offset)} &&
    ptr_of($past(op_ptr)) == $past(ptr_val))
    else $error("offset access wrong");
  a_postinc_step: assert property (acc && (is_ld || is_st) && m_post |=>
    ptr_of($past(op_ptr)) == $past(ptr_val) + 16'h0001)
    else $error("post-increment step wrong");
  a_sram_extra: assert property (acc && is_ld && m_post && in_sram && !to_ext |=>
    !op_ready ##1 !op_ready ##1 op_ready && op_done)
    else $error("internal SRAM load length wrong");
  a_pop_length: assert property (acc && is_pop && in_sram && !to_ext |=>
    stack_pointer == $past(stack_pointer) + 16'h0001 && !op_ready ##1
    !op_ready[*2] ##1 op_done)
    else $error("pop length wrong");
  a_cycle_count: assert property (op_done && !exp_ext |->
    busy_len == {1'b0, exp_total})
    else $error("busy length differs from count");
  a_direct_store: assert property (acc && op_code == xfer_pkg::OP_STORE_DIRECT |=>
    data_wr && data_addr == $past(op_addr))
    else $error("direct store wrong");
  a_prog_page: assert property (acc && is_prd |=> prog_rd &&
    prog_addr[15:0] == $past(z_val) &&
    prog_addr[23:16] == ($past(op_code) == xfer_pkg::OP_PROG_READ_EXT ?
                         $past(extended_z_page) : 8'h00))
    else $error("program read address wrong");
  a_prog_write: assert property (acc && is_pwr && m_post |=>
    prog_wr && z_val == $past(z_val) + 16'h0002 && prog_wdata == $past({regs[1], regs[0]}))
    else $error("program write step wrong");
  a_io_bit: assert property (acc && op_code == xfer_pkg::OP_IO_SET |=>
    io_wr && io_mask == (8'h01 << $past(op_bit)) && io_wdata == 8'hff &&
    io_addr == $past(op_io_addr))
    else $error("io bit set wrong");
  a_ext_hold: assert property (state == xfer_pkg::ST_EXT && !ack_seen |=>
    !op_ready && (strb != 6'h00))
    else $error("external wait released early");
  a_rol_carry: assert property (acc && op_code == xfer_pkg::OP_ROL |=>
    status_flags_register[0] == $past(src[7]) ##1 op_done)
    else $error("rotate carry wrong");
  a_t_copy: assert property (acc && op_code == xfer_pkg::OP_BIT_TO_FLAG |=>
    status_flags_register[6] == $past(src[op_bit]) &&
    status_flags_register[5:0] == $past(status_flags_register[5:0]))
    else $error("bit to flag wrong");
  a_t_place: assert property (acc && op_code == xfer_pkg::OP_FLAG_TO_BIT |=>
    status_flags_register == $past(status_flags_register))
    else $error("flag to bit changed flags");
  a_flag_force: assert property (acc && op_code == xfer_pkg::OP_FLAG_SET |=>
    status_flags_register[$past(op_bit)] ##1 op_done)
    else $error("flag set wrong");

endmodule // xfer_exec

// [verilog/xfer_pkg.sv]
// Shared types and constants for the load, store and bit-operation unit.
// Assumes an 8-bit core with a 32-entry register file and 16-bit pointers.
package xfer_pkg;

  // Operations carried out by the unit.
  typedef enum logic [4:0] {
    OP_LOAD, OP_STORE, OP_LOAD_DIRECT, OP_STORE_DIRECT,
    OP_PROG_READ, OP_PROG_READ_EXT, OP_PROG_WRITE,
    OP_IO_IN, OP_IO_OUT, OP_IO_SET, OP_IO_CLR,
    OP_PUSH, OP_POP, OP_ROL, OP_ROR,
    OP_BIT_TO_FLAG, OP_FLAG_TO_BIT, OP_FLAG_SET, OP_FLAG_CLR
  } op_t;

  // Pointer addressing modes; implied selects register zero as program read destination.
  typedef enum logic [2:0] {
    AM_PLAIN, AM_POST_INC, AM_PRE_DEC, AM_OFFSET, AM_IMPLIED
  } mode_t;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN  = 3'h2,
    ST_EXT  = 3'h4
  } state_t;

  // Source of the byte captured into the destination register.
  typedef enum logic [1:0] {CAP_NONE, CAP_DATA, CAP_PROG, CAP_IO} cap_t;

  // Flag positions in the status flags register.
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;

  // Low register index of each pointer pair.
  localparam logic [4:0] X_LO = 5'h1a;
  localparam logic [4:0] Y_LO = 5'h1c;
  localparam logic [4:0] Z_LO = 5'h1e;

  localparam logic [2:0]  CYC_ONE        = 3'h1;
  localparam logic [2:0]  CYC_PAIR       = 3'h2;
  localparam logic [2:0]  CYC_PROG       = 3'h3;
  localparam logic [2:0]  CYC_PROG_WRITE = 3'h2;
  localparam logic [2:0]  SRAM_EXTRA     = 3'h1;
  localparam logic [15:0] PTR_STEP       = 16'h0001;
  localparam logic [15:0] WORD_STEP      = 16'h0002;
  localparam logic [7:0]  ALL_ONES       = 8'hff;
  localparam logic [7:0]  NO_PAGE        = 8'h00;

  // Listed cycle count of an operation, before the internal SRAM extra.
  function automatic logic [2:0] base_cycles(op_t op, mode_t m);
    case (op)
      OP_LOAD, OP_STORE:
        base_cycles = (m == AM_PRE_DEC || m == AM_OFFSET) ? CYC_PAIR : CYC_ONE;
      OP_LOAD_DIRECT, OP_STORE_DIRECT, OP_POP: base_cycles = CYC_PAIR;
      OP_PROG_READ, OP_PROG_READ_EXT: base_cycles = CYC_PROG;
      OP_PROG_WRITE: base_cycles = CYC_PROG_WRITE;
      default: base_cycles = CYC_ONE;
    endcase
  endfunction

  // True for operations that reach the data space.
  function automatic logic is_data(op_t op);
    is_data = (op == OP_LOAD) || (op == OP_STORE) || (op == OP_LOAD_DIRECT) ||
              (op == OP_STORE_DIRECT) || (op == OP_PUSH) || (op == OP_POP);
  endfunction

endpackage

// [verilog/rotate_carry_unit.sv]
// Rotate-through-carry datapath with its flag results.
// Assumes the caller picks which flags to keep for each direction.
`timescale 1ns/1ns
module rotate_carry_unit (
  input  wire logic [7:0] value,
  input  wire logic       carry_in,
  input  wire logic       to_left,
  output logic      [7:0] result,
  output logic            flag_c,
  output logic            flag_z,
  output logic            flag_n,
  output logic            flag_v,
  output logic            flag_h
);

  // Old carry enters the vacated end; the bit shifted out becomes carry.
  assign result = to_left ? {value[6:0], carry_in} : {carry_in, value[7:1]};
  assign flag_c = to_left ? value[7] : value[0];
  assign flag_h = value[3];
  assign flag_n = result[7];
  assign flag_z = (result == 8'h00);
  assign flag_v = flag_n ^ flag_c;

endmodule // rotate_carry_unit

// [tb/mem_model.sv]
// Behavioural data, program and I/O memories facing the transfer unit.
// Assumes reads are answered in the strobe cycle and data at 8000 and up is external.
`timescale 1ns/1ns
module mem_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] data_addr,
  input  wire logic [7:0]  data_wdata,
  input  wire logic        data_rd,
  input  wire logic        data_wr,
  input  wire logic [23:0] prog_addr,
  input  wire logic        prog_rd,
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_rd,
  output logic      [7:0]  data_rdata,
  output logic      [7:0]  prog_rdata,
  output logic      [7:0]  io_rdata,
  output logic             ext_ack,
  output logic      [23:0] last_wr
);
  // Bytes hash the address; off strobe the bus shows the inverse.
  assign data_rdata = {8{~data_rd}} ^ data_addr[7:0] ^ data_addr[15:8] ^ 8'h3c;
  assign prog_rdata = {8{~prog_rd}} ^ prog_addr[7:0] ^ prog_addr[15:8] ^ prog_addr[23:16];
  assign io_rdata   = {8{~io_rd}} ^ {2'h0, io_addr} ^ 8'ha5;
  // External space acks one cycle into the strobe; writes are logged.
  always_ff @(posedge ref_clk)
  begin
    ext_ack <= (data_rd | data_wr) & data_addr[15];
    if (data_wr)
      last_wr <= {data_wdata, data_addr};
  end
endmodule // mem_model

// [tb/tb_xfer_exec.sv]
// Self-checking bench for the load, store and bit-operation unit.
// Assumes the unit's default address map and the behavioural memory model.
`timescale 1ns/1ns
module tb_xfer_exec;
  typedef struct {time t; int n; logic [7:0] rv; logic [7:0] sr; logic [23:0] wr;} note_t;
  logic ref_clk, sys_rst, op_valid, ext_ack, reg_load, op_ready, op_done;
  logic data_rd, data_wr, prog_rd, prog_wr, io_rd, io_wr;
  xfer_pkg::op_t   op_code;
  xfer_pkg::mode_t op_mode;
  xfer_pkg::ptr_t  op_ptr;
  logic [4:0]  op_reg, reg_load_idx, reg_sel;
  logic [2:0]  op_bit;
  logic [5:0]  op_offset, op_io_addr, io_addr;
  logic [15:0] op_addr, data_addr, stack_pointer, prog_wdata;
  logic [7:0]  extended_z_page, data_rdata, prog_rdata, io_rdata, reg_load_data;
  logic [7:0]  data_wdata, io_wdata, io_mask, status_flags_register, reg_value, sr;
  logic [23:0] prog_addr, last_wr, wr;
  logic [7:0]  rg [32];
  note_t       q [$];
  int          fails, n_tests;
  xfer_exec dut (.*);
  mem_model mem (.*);
  // Clock of 10 ns period.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] fd(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [7:0] fp(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction
  task automatic bad(input string m);
    fails++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Presets one register through the load port.
  task automatic wreg(input logic [4:0] i, input logic [7:0] d);
    @(posedge ref_clk);
    reg_load      <= 1'b1;
    reg_load_idx  <= i;
    reg_load_data <= d;
    @(posedge ref_clk);
    reg_load <= 1'b0;
    rg[i] = d;
  endtask
  // Issues one operation, notes its result and waits for completion.
  task automatic issue(input xfer_pkg::op_t c, input xfer_pkg::mode_t m, input logic [4:0] r,
                       input logic [7:0] v, input int n, input logic [15:0] a = 16'h0000,
                       input logic [2:0] b = 3'h0, input xfer_pkg::ptr_t p = xfer_pkg::PTR_X);
    int i;
    @(posedge ref_clk);
    op_valid   <= 1'b1;
    op_code    <= c;
    op_mode    <= m;
    op_ptr     <= p;
    op_reg     <= r;
    op_bit     <= b;
    op_addr    <= a;
    op_offset  <= a[5:0];
    op_io_addr <= a[5:0];
    reg_sel    <= r;
    @(posedge ref_clk);
    q.push_back('{$time, n, v, sr, wr});
    op_valid <= 1'b0;
    rg[r] = v;
    for (i = 0; i < 50 && op_done !== 1'b1; i++)
      @(negedge ref_clk);
    if (op_done !== 1'b1) bad("no completion");
    repeat (3) @(posedge ref_clk);
  endtask
  // Compares each completion with the oldest note.
  always @(posedge ref_clk)
    if (op_done === 1'b1)
    begin
      note_t e;
      if (q.size() == 0) bad("completion without request");
      e = q.pop_front();
      n_tests += 4;
      if (e.n > 0 && ($time - e.t) / 10 != e.n + 1) bad("wrong cycle count");
      @(posedge ref_clk);
      #1;
      if (reg_value !== e.rv) bad("register value");
      if (status_flags_register !== e.sr) bad("status flags");
      if (last_wr !== e.wr) bad("data store");
    end
  // Watchdog: the run needs under 1000 cycles.
  initial
  begin
    #100000;
    bad("timeout");
    give_verdict();
  end
  initial
  begin
    logic [7:0] v, res, pg;
    logic       c;
    logic [2:0] fl;
    {op_valid, reg_load, op_reg, op_bit, op_offset} = '0;
    {op_addr, op_io_addr, reg_load_idx, reg_load_data, reg_sel, extended_z_page} = '0;
    {sr, fails, n_tests} = '0;
    sys_rst = 1'b1;
    void'($urandom(32'h6b06));
    pg = 8'($urandom);
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    extended_z_page <= pg;
    for (int i = 0; i < 32; i++) rg[i] = 8'h00;
    for (int i = 0; i < 26; i++) wreg(i[4:0], 8'($urandom));
    wreg(27, 8'h02); // X = 0200, Y = 2000 in SRAM, Z = 0300.
    wreg(29, 8'h20);
    wreg(31, 8'h03);
    $display("preset done");
    wr = {rg[9], 16'h0400};
    issue(xfer_pkg::OP_STORE_DIRECT, xfer_pkg::AM_PLAIN, 9, rg[9], 2, 16'h0400);
    issue(xfer_pkg::OP_LOAD, xfer_pkg::AM_POST_INC, 5, fd(16'h0200), 1);
    issue(xfer_pkg::OP_LOAD, xfer_pkg::AM_PLAIN, 6, fd(16'h0201), 1);
    issue(xfer_pkg::OP_LOAD, xfer_pkg::AM_PRE_DEC, 7, fd(16'h02ff), 2, 0, 0, xfer_pkg::PTR_Z);
    issue(xfer_pkg::OP_LOAD, xfer_pkg::AM_OFFSET, 8, fd(16'h033e), 2, 16'h003f, 0, xfer_pkg::PTR_Z);
    issue(xfer_pkg::OP_LOAD, xfer_pkg::AM_OFFSET, 10, fd(16'h2001), 3, 1, 0, xfer_pkg::PTR_Y);
    wr = {rg[11], 16'h0201};
    issue(xfer_pkg::OP_STORE, xfer_pkg::AM_POST_INC, 11, rg[11], 1);
    wr = {rg[12], 16'h0201};
    issue(xfer_pkg::OP_STORE, xfer_pkg::AM_PRE_DEC, 12, rg[12], 2);
    wr = {rg[13], 16'h2005};
    issue(xfer_pkg::OP_STORE, xfer_pkg::AM_OFFSET, 13, rg[13], 3, 5, 0, xfer_pkg::PTR_Y);
    wr = {rg[5], 16'h4fff};
    issue(xfer_pkg::OP_PUSH, xfer_pkg::AM_PLAIN, 5, rg[5], 2);
    issue(xfer_pkg::OP_POP, xfer_pkg::AM_PLAIN, 14, fd(16'h4fff), 3);
    issue(xfer_pkg::OP_LOAD, xfer_pkg::AM_POST_INC, 23, fd(16'h2000), 2, 0, 0, xfer_pkg::PTR_Y);
    issue(xfer_pkg::OP_LOAD_DIRECT, xfer_pkg::AM_PLAIN, 15, fd(16'h9000), 0, 16'h9000);
    $display("data tests done");
    issue(xfer_pkg::OP_PROG_READ, xfer_pkg::AM_IMPLIED, 0, fp(24'h0002ff), 3);
    issue(xfer_pkg::OP_PROG_READ_EXT, xfer_pkg::AM_POST_INC, 16, fp({pg, 16'h02ff}), 3);
    issue(xfer_pkg::OP_PROG_WRITE, xfer_pkg::AM_POST_INC, 0, rg[0], 2);
    issue(xfer_pkg::OP_PROG_READ, xfer_pkg::AM_PLAIN, 17, fp(24'h000302), 3);
    $display("program tests done");
    issue(xfer_pkg::OP_IO_IN, xfer_pkg::AM_PLAIN, 18, 8'h12 ^ 8'ha5, 1, 16'h0012);
    issue(xfer_pkg::OP_IO_OUT, xfer_pkg::AM_PLAIN, 19, rg[19], 1, 16'h0013);
    issue(xfer_pkg::OP_IO_SET, xfer_pkg::AM_PLAIN, 19, rg[19], 1, 16'h0014, 3);
    issue(xfer_pkg::OP_IO_CLR, xfer_pkg::AM_PLAIN, 19, rg[19], 1, 16'h0014, 4);
    $display("io tests done");
    // Rotates alternate; the first gives zero with carry out.
    for (int k = 0; k < 8; k++)
    begin
      v = (k == 0) ? 8'h80 : 8'($urandom);
      wreg(20, v);
      c = sr[xfer_pkg::FLAG_C];
      res = k[0] ? {c, v[7:1]} : {v[6:0], c};
      sr[xfer_pkg::FLAG_C] = k[0] ? v[0] : v[7];
      sr[xfer_pkg::FLAG_Z] = (res == 8'h00);
      sr[xfer_pkg::FLAG_N] = res[7];
      sr[xfer_pkg::FLAG_V] = res[7] ^ sr[xfer_pkg::FLAG_C];
      if (!k[0]) sr[xfer_pkg::FLAG_H] = v[3];
      issue(k[0] ? xfer_pkg::OP_ROR : xfer_pkg::OP_ROL, xfer_pkg::AM_PLAIN, 20, res, 1);
    end
    $display("rotate tests done");
    for (int b = 0; b < 8; b++)
    begin
      sr[xfer_pkg::FLAG_T] = rg[21][b];
      issue(xfer_pkg::OP_BIT_TO_FLAG, xfer_pkg::AM_PLAIN, 21, rg[21], 1, 0, b[2:0]);
      v = rg[22];
      v[7 - b] = sr[xfer_pkg::FLAG_T];
      issue(xfer_pkg::OP_FLAG_TO_BIT, xfer_pkg::AM_PLAIN, 22, v, 1, 0, 3'(7 - b));
    end
    for (int k = 0; k < 6; k++)
    begin
      fl = (k < 2) ? xfer_pkg::FLAG_V : (k < 4) ? xfer_pkg::FLAG_H : xfer_pkg::FLAG_S;
      sr[fl] = !k[0];
      issue(k[0] ? xfer_pkg::OP_FLAG_CLR : xfer_pkg::OP_FLAG_SET, xfer_pkg::AM_PLAIN, 0, rg[0], 1, 0, fl);
    end
    $display("flag tests done");
    give_verdict();
  end
endmodule // tb_xfer_exec
